// ---- rtl/rrh_core.sv ----
// Notes on behaviour
// - return-if-plus pops into pc when sign is 0, else goes sequential.
// - return-if-parity-even pops into pc when parity is 1, else sequential.
// - return-if-parity-odd pops into pc when parity is 0, else sequential.
// - restart pushes the address of the following instruction, not its own.
// - restart jumps to one of eight 8-byte slots in the lowest 64 bytes.
// - restart is one byte long, unlike the three-byte call.
// - an external request is served by a restart to a fixed slot.
// - one interrupt flip-flop; at 0 external requests force no restart.
// - the unmask instruction sets the flip-flop, flags untouched.
// - the mask instruction clears the flip-flop, flags untouched.
// - port input loads the selected port byte into the accumulator.
// - port output drives the accumulator to the selected port.
// - halt adds one to pc, then stops; flags untouched.
// - returns never modify any condition flag.
`timescale 1ns/1ps
`include "rrh_cfg.svh"
`default_nettype none

module rrh_core
    import rrh_pkg::*;
(
    input  wire logic     mclk,
    input  wire logic     rst_n,
    input  wire rrh_req_t req,
    input  wire logic     irq_pin,
    output rrh_rsp_t      rsp
);

    rrh_regs_t   q;
    rrh_regs_t   d;
    logic        take_irq;
    logic        dec_ok;
    logic [15:0] pc_inc1;
    logic [15:0] pc_inc2;
    logic [15:0] irq_vec;
    logic        is_rst;

    assign pc_inc1  = req.pc_cur + `RRH_LEN_ONE;
    assign pc_inc2  = req.pc_cur + `RRH_LEN_TWO;
    assign irq_vec  = {10'h000, `RRH_IRQ_SLOT, 3'h0};
    assign is_rst   = (req.opcode & `RRH_RST_MASK) == `RRH_RST_BASE;
    assign take_irq = q.rsp.int_en & q.irq_lvl;
    assign dec_ok   = req.valid && (q.st == RRH_ST_RUN) && !take_irq;

    always_comb begin
        d             = q;
        d.rsp.done    = 1'b0;
        d.rsp.push    = 1'b0;
        d.rsp.pop     = 1'b0;
        d.rsp.acc_we  = 1'b0;
        d.rsp.port_rd = 1'b0;
        d.rsp.port_wr = 1'b0;
        d.rsp.irq_ack = 1'b0;
        // three stages; a change counts once the last two agree
        d.irq_sync    = {q.irq_sync[1:0], irq_pin};
        if (q.irq_sync[1] == q.irq_sync[2]) begin
            d.irq_lvl = q.irq_sync[2];
        end
        unique case (q.st)
            RRH_ST_RUN: begin
                if (req.valid && take_irq) begin
                    // forced restart; the presented instruction is re-fetched later
                    d.rsp.push      = 1'b1;
                    d.rsp.push_data = req.pc_cur;
                    d.rsp.pc_next   = irq_vec;
                    d.rsp.irq_ack   = 1'b1;
                    d.rsp.done      = 1'b1;
                    d.rsp.int_en    = 1'b0;
                end else if (req.valid) begin
                    d.rsp.done    = 1'b1;
                    d.rsp.pc_next = pc_inc1;
                    if (req.opcode == `RRH_OP_RET_PLUS) begin
                        if (!req.flag_sign) begin
                            d.rsp.pop     = 1'b1;
                            d.rsp.pc_next = req.stack_top;
                        end
                    end else if (req.opcode == `RRH_OP_RET_PAR_EVEN) begin
                        if (req.flag_parity) begin
                            d.rsp.pop     = 1'b1;
                            d.rsp.pc_next = req.stack_top;
                        end
                    end else if (req.opcode == `RRH_OP_RET_PAR_ODD) begin
                        if (!req.flag_parity) begin
                            d.rsp.pop     = 1'b1;
                            d.rsp.pc_next = req.stack_top;
                        end
                    end else if (is_rst) begin
                        d.rsp.push      = 1'b1;
                        d.rsp.push_data = pc_inc1;
                        d.rsp.pc_next   = {10'h000, req.opcode[`RRH_RST_SLOT_MSB:`RRH_RST_SLOT_LSB], 3'h0};
                    end else if (req.opcode == `RRH_OP_INT_UNMASK) begin
                        d.rsp.int_en = 1'b1;
                    end else if (req.opcode == `RRH_OP_INT_MASK) begin
                        d.rsp.int_en = 1'b0;
                    end else if (req.opcode == `RRH_OP_PORT_IN) begin
                        d.rsp.done      = 1'b0;
                        d.rsp.port_rd   = 1'b1;
                        d.rsp.port_addr = req.operand;
                        d.rsp.pc_next   = pc_inc2;
                        d.st            = RRH_ST_PORT_IN;
                    end else if (req.opcode == `RRH_OP_PORT_OUT) begin
                        d.rsp.port_wr    = 1'b1;
                        d.rsp.port_addr  = req.operand;
                        d.rsp.port_wdata = req.acc;
                        d.rsp.pc_next    = pc_inc2;
                    end else if (req.opcode == `RRH_OP_STOP_EXEC) begin
                        d.rsp.halted = 1'b1;
                        d.st         = RRH_ST_HALT;
                    end
                end
            end
            RRH_ST_PORT_IN: begin
                d.rsp.acc_we   = 1'b1;
                d.rsp.acc_data = req.port_rdata;
                d.rsp.done     = 1'b1;
                d.st           = RRH_ST_RUN;
            end
            RRH_ST_HALT: begin
                // only an accepted request leaves halt; pc_next already points past it
                if (take_irq) begin
                    d.rsp.push      = 1'b1;
                    d.rsp.push_data = q.rsp.pc_next;
                    d.rsp.pc_next   = irq_vec;
                    d.rsp.irq_ack   = 1'b1;
                    d.rsp.done      = 1'b1;
                    d.rsp.int_en    = 1'b0;
                    d.rsp.halted    = 1'b0;
                    d.st            = RRH_ST_RUN;
                end
            end
        endcase
        d.rsp.ready = (d.st == RRH_ST_RUN);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q             <= '0;
            q.st          <= RRH_ST_RUN;
            q.rsp.ready   <= 1'b1;
            q.rsp.pc_next <= `RRH_RST_PC;
            q.rsp.int_en  <= `RRH_RST_INT_EN;
        end else begin
            q <= d;
        end
    end

    assign rsp = q.rsp;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_ret_plus_taken: assert property (
        dec_ok && req.opcode == `RRH_OP_RET_PLUS |=>
        rsp.pop == !$past(req.flag_sign) &&
        rsp.pc_next == ($past(req.flag_sign) ? $past(pc_inc1) : $past(req.stack_top)))
        else $error("return-if-plus took the wrong path");

    a_ret_even_cond: assert property (
        dec_ok && req.opcode == `RRH_OP_RET_PAR_EVEN |=> rsp.pop == $past(req.flag_parity) && rsp.done)
        else $error("return-if-parity-even condition wrong");

    a_ret_odd_cond: assert property (
        dec_ok && req.opcode == `RRH_OP_RET_PAR_ODD |=> rsp.pop == !$past(req.flag_parity) && rsp.done)
        else $error("return-if-parity-odd condition wrong");

    a_rst_push_next: assert property (
        dec_ok && is_rst |=> rsp.push && rsp.push_data == $past(req.pc_cur) + `RRH_LEN_ONE)
        else $error("restart pushed the wrong address");

    a_rst_slot_vec: assert property (
        dec_ok && is_rst |=> rsp.pc_next[15:6] == 10'h000 && rsp.pc_next[2:0] == 3'h0 &&
        rsp.pc_next[5:3] == $past(req.opcode[5:3]))
        else $error("restart vector outside its slot");

    a_irq_blocked: assert property (
        !rsp.int_en |=> !rsp.irq_ack)
        else $error("request accepted while masked");

    a_irq_clears_en: assert property (
        rsp.irq_ack |-> !rsp.int_en && rsp.pc_next == irq_vec && rsp.push)
        else $error("accepted request left the flip-flop set");

    // a mask op right behind the unmask is legal and may clear it again
    a_unmask_sets: assert property (
        dec_ok && req.opcode == `RRH_OP_INT_UNMASK |=>
        rsp.int_en ##1 (rsp.int_en || rsp.irq_ack || $past(dec_ok && req.opcode == `RRH_OP_INT_MASK)))
        else $error("unmask did not set the flip-flop");

    a_mask_clears: assert property (
        dec_ok && req.opcode == `RRH_OP_INT_MASK |=> !rsp.int_en)
        else $error("mask did not clear the flip-flop");

    a_port_in_load: assert property (
        rsp.port_rd |=> rsp.acc_we && rsp.done && rsp.acc_data == $past(req.port_rdata))
        else $error("port input not loaded");

    a_port_out_drive: assert property (
        dec_ok && req.opcode == `RRH_OP_PORT_OUT |=> rsp.port_wr && rsp.port_wdata == $past(req.acc) &&
        rsp.port_addr == $past(req.operand))
        else $error("port output data wrong");

    a_halt_stop: assert property (
        dec_ok && req.opcode == `RRH_OP_STOP_EXEC |=>
        rsp.halted && rsp.pc_next == $past(req.pc_cur) + `RRH_LEN_ONE && !rsp.ready)
        else $error("halt did not stop past itself");

endmodule : rrh_core

`default_nettype wire

// ---- rtl/rrh_cfg.svh ----
`ifndef RRH_CFG_SVH
`define RRH_CFG_SVH

// opcode encodings of the group
`define RRH_OP_RET_PLUS      8'hF0
`define RRH_OP_RET_PAR_EVEN  8'hE8
`define RRH_OP_RET_PAR_ODD   8'hE0
`define RRH_OP_INT_UNMASK    8'hFB
`define RRH_OP_INT_MASK      8'hF3
`define RRH_OP_PORT_IN       8'hDB
`define RRH_OP_PORT_OUT      8'hD3
`define RRH_OP_STOP_EXEC     8'h76

// restart: 11 vvv 111, vvv selects the slot
`define RRH_RST_MASK         8'hC7
`define RRH_RST_BASE         8'hC7
`define RRH_RST_SLOT_LSB     3
`define RRH_RST_SLOT_MSB     5

// byte lengths added to the program counter
`define RRH_LEN_ONE          16'h0001
`define RRH_LEN_TWO          16'h0002

// slot used by an accepted external request
`define RRH_IRQ_SLOT         3'h7

// reset values
`define RRH_RST_PC           16'h0000
`define RRH_RST_INT_EN       1'b0

`endif

// ---- rtl/rrh_pkg.sv ----
`default_nettype none

package rrh_pkg;

    typedef enum logic [2:0] {
        RRH_ST_RUN     = 3'b001,
        RRH_ST_PORT_IN = 3'b010,
        RRH_ST_HALT    = 3'b100
    } rrh_state_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  opcode;
        logic [7:0]  operand;
        logic [15:0] pc_cur;
        logic [7:0]  acc;
        logic        flag_sign;
        logic        flag_parity;
        logic [15:0] stack_top;
        logic [7:0]  port_rdata;
    } rrh_req_t;

    typedef struct packed {
        logic        ready;
        logic        done;
        logic [15:0] pc_next;
        logic        push;
        logic [15:0] push_data;
        logic        pop;
        logic        acc_we;
        logic [7:0]  acc_data;
        logic [7:0]  port_addr;
        logic [7:0]  port_wdata;
        logic        port_rd;
        logic        port_wr;
        logic        int_en;
        logic        halted;
        logic        irq_ack;
    } rrh_rsp_t;

    typedef struct packed {
        rrh_state_t st;
        logic [2:0] irq_sync;
        logic       irq_lvl;
        rrh_rsp_t   rsp;
    } rrh_regs_t;

endpackage : rrh_pkg

`default_nettype wire

// ---- verif/rrh_port_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rrh_port_model
    import rrh_pkg::*;
(
    input  wire logic     mclk,
    input  wire logic     rst_n,
    input  wire rrh_rsp_t rsp,
    input  wire logic     want_irq,
    output logic [7:0]    port_rdata,
    output logic          irq_pin,
    output logic [7:0]    last_wdata
);
    logic want_q;
    // port read data
    // outside a read the bus shows the inverse, so stale data never matches
    always_comb port_rdata = rsp.port_rd ? (rsp.port_addr ^ 8'hA5) : ~(rsp.port_addr ^ 8'hA5);
    // request raised on a rising want, held until acknowledged or want falls, writes captured
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            want_q <= 1'b0;
            irq_pin <= 1'b0;
            last_wdata <= 8'h00;
        end else begin
            want_q <= want_irq;
            if (!want_irq || rsp.irq_ack) irq_pin <= 1'b0;
            else if (!want_q) irq_pin <= 1'b1;
            if (rsp.port_wr) last_wdata <= rsp.port_wdata;
        end
    end
endmodule : rrh_port_model
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`include "rrh_cfg.svh"
`default_nettype none
module testbench
    import rrh_pkg::*;
;
    typedef struct packed {
        logic [7:0]  op;
        logic        s;
        logic        p;
        logic [15:0] pc;
        logic        pop;
        logic        ie;
    } rrh_row_t;
    logic      mclk = 1'b0;
    logic      rst_n = 1'b0;
    logic      want = 1'b0;
    logic      irq_pin;
    logic [7:0] rdata;
    logic [7:0] wdata;
    rrh_req_t  req = '0;
    rrh_req_t  rq;
    rrh_rsp_t  rsp;
    rrh_rsp_t  r;
    int        fail_count = 0;
    int        compares = 0;
    int        cyc = 0;
    rrh_row_t  rows [9];
    always #10 mclk = ~mclk;
    always_comb begin
        rq = req;
        rq.port_rdata = rdata;
    end
    rrh_core DUT (.mclk(mclk), .rst_n(rst_n), .req(rq), .irq_pin(irq_pin), .rsp(rsp));
    rrh_port_model u_port (.mclk(mclk), .rst_n(rst_n), .rsp(rsp), .want_irq(want),
                           .port_rdata(rdata), .irq_pin(irq_pin), .last_wdata(wdata));
    task automatic final_report();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // present one instruction, wait a bounded time for done
    task automatic run(input logic [7:0] op, input logic [7:0] opd, input logic [15:0] pc, input logic s,
                       input logic p);
        int n;
        @(negedge mclk);
        req.valid = 1'b1;
        req.opcode = op;
        req.operand = opd;
        req.pc_cur = pc;
        req.flag_sign = s;
        req.flag_parity = p;
        @(negedge mclk);
        req.valid = 1'b0;
        r = rsp;
        n = 0;
        while (r.done !== 1'b1 && n < 4) begin
            @(negedge mclk);
            r = rsp;
            n++;
        end
    endtask : run
    task automatic wait_ack();
        int n;
        n = 0;
        r = rsp;
        while (r.irq_ack !== 1'b1 && n < 12) begin
            @(negedge mclk);
            r = rsp;
            n++;
        end
    endtask : wait_ack
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        rows[0] = {`RRH_OP_RET_PLUS, 2'b00, 16'hBEEF, 2'b10};
        rows[1] = {`RRH_OP_RET_PLUS, 2'b10, 16'h1231, 2'b00};
        rows[2] = {`RRH_OP_RET_PAR_EVEN, 2'b01, 16'hBEEF, 2'b10};
        rows[3] = {`RRH_OP_RET_PAR_EVEN, 2'b00, 16'h1231, 2'b00};
        rows[4] = {`RRH_OP_RET_PAR_ODD, 2'b00, 16'hBEEF, 2'b10};
        rows[5] = {`RRH_OP_RET_PAR_ODD, 2'b01, 16'h1231, 2'b00};
        rows[6] = {`RRH_OP_INT_UNMASK, 2'b00, 16'h1231, 2'b01};
        rows[7] = {`RRH_OP_RET_PLUS, 2'b11, 16'h1231, 2'b01};
        rows[8] = {`RRH_OP_INT_MASK, 2'b00, 16'h1231, 2'b00};
        req.stack_top = 16'hBEEF;
        req.acc = 8'h99;
        repeat (16) @(negedge mclk);
        chk("reset ready", 1, rsp.ready);
        chk("reset pc", 16'h0000, rsp.pc_next);
        chk("reset int_en", 0, {rsp.int_en, rsp.halted});
        rst_n = 1'b1;
        foreach (rows[i]) begin
            run(rows[i].op, 8'h00, 16'h1230, rows[i].s, rows[i].p);
            chk("row pc", rows[i].pc, r.pc_next);
            chk("row pop", rows[i].pop, r.pop);
            chk("row int_en", rows[i].ie, r.int_en);
            chk("row side", 0, {r.push, r.acc_we, r.port_wr});
        end
        for (int n = 0; n < 8; n++) begin
            run(`RRH_RST_BASE | 8'(n << 3), 8'h00, 16'h1230, 1'b0, 1'b0);
            chk("rst push", 16'h1231, r.push ? r.push_data : 16'h0000);
            chk("rst pc", 16'(n * 8), r.pc_next);
        end
        run(`RRH_OP_PORT_OUT, 8'h42, 16'h1230, 1'b0, 1'b0);
        chk("out", 16'h4299, {r.port_addr, r.port_wdata});
        chk("out wr pc", 16'h1232, r.port_wr ? r.pc_next : 16'h0000);
        @(negedge mclk);
        chk("out seen", 8'h99, wdata);
        run(`RRH_OP_PORT_IN, 8'h17, 16'h1230, 1'b0, 1'b0);
        chk("in acc", 16'h01B2, {7'h00, r.acc_we, r.acc_data});
        chk("in pc", 16'h1232, r.pc_next);
        run(`RRH_OP_INT_UNMASK, 8'h00, 16'h1FFF, 1'b0, 1'b0);
        run(`RRH_OP_STOP_EXEC, 8'h00, 16'h2000, 1'b0, 1'b0);
        chk("halt", 16'h2001, r.pc_next);
        @(negedge mclk);
        chk("halted", 2, {rsp.halted, rsp.ready});
        run(`RRH_OP_INT_MASK, 8'h00, 16'h2001, 1'b0, 1'b0);
        chk("refused", 1, {r.done, r.int_en});
        want = 1'b1;
        wait_ack();
        chk("wake push", 16'h2001, r.push_data);
        chk("wake pc", 16'h0038, r.pc_next);
        chk("wake flags", 0, {r.halted, r.int_en});
        want = 1'b0;
        run(`RRH_OP_INT_UNMASK, 8'h00, 16'h3000, 1'b0, 1'b0);
        want = 1'b1;
        repeat (6) @(negedge mclk);
        run(8'h00, 8'h00, 16'h3001, 1'b0, 1'b0);
        chk("irq ack", 1, r.irq_ack);
        chk("irq push", 16'h3001, r.push_data);
        chk("irq int_en", 0, r.int_en);
        want = 1'b0;
        repeat (2) @(negedge mclk);
        want = 1'b1;
        repeat (6) @(negedge mclk);
        run(8'h00, 8'h00, 16'h4000, 1'b0, 1'b0);
        chk("masked", 16'h4001, r.irq_ack ? 16'h0000 : r.pc_next);
        want = 1'b0;
        // let the synced request fall first, else the halt is pre-empted by a restart
        repeat (6) @(negedge mclk);
        run(`RRH_OP_INT_UNMASK, 8'h00, 16'h5000, 1'b0, 1'b0);
        run(`RRH_OP_STOP_EXEC, 8'h00, 16'h5001, 1'b0, 1'b0);
        chk("halt again", 16'h5002, r.pc_next);
        @(negedge mclk);
        chk("halted again", 2, {rsp.halted, rsp.ready});
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        chk("rerst", 16'h0001, {rsp.pc_next[14:0], rsp.ready});
        chk("rerst flags", 0, {rsp.halted, rsp.int_en});
        rst_n = 1'b1;
        // first request right after the release must run normally
        run(`RRH_OP_RET_PLUS, 8'h00, 16'h6000, 1'b0, 1'b0);
        chk("rerst ret", 16'hBEEF, r.pc_next);
        chk("rerst pop", 2, {r.pop, r.halted});
        final_report();
    end
endmodule : testbench
`default_nettype wire
